// ### common/mbr_pkg.sv
// Shared constants and types for the move, OR, branch and return execution block.
package mbr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int PC_W       = 11;
    localparam int FADDR_W    = 5;
    localparam int INSTR_W    = 12;
    localparam int FILE_DEPTH = 32;

    // ------------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------------
    localparam int DEST_BIT   = 5;
    localparam int BR_K_MSB   = 8;
    localparam int LIT_MSB    = 7;
    localparam int FADDR_MSB  = 4;

    // ------------------------------------------------------------------
    // Flag register layout and reset values
    // ------------------------------------------------------------------
    localparam int ZERO_BIT    = 2;
    localparam int PAGE_LO_BIT = 5;
    localparam int PAGE_HI_BIT = 6;
    localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
    localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
    localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST     = 11'h000;

    // ------------------------------------------------------------------
    // Opcode patterns, matched on the upper bits named in each width
    // ------------------------------------------------------------------
    localparam logic [2:0]  OPC_BRANCH   = 3'h5;
    localparam logic [3:0]  OPC_OR_LIT   = 4'hd;
    localparam logic [3:0]  OPC_LOAD_LIT = 4'hc;
    localparam logic [3:0]  OPC_RETURN   = 4'h8;
    localparam logic [5:0]  OPC_OR_FILE  = 6'h04;
    localparam logic [5:0]  OPC_COPY     = 6'h08;
    localparam logic [6:0]  OPC_STORE    = 7'h01;
    localparam logic [11:0] OPC_IDLE     = 12'h000;
    localparam logic [11:0] OPC_CONFIG   = 12'h002;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE, OP_BRANCH, OP_OR_LIT, OP_OR_FILE, OP_STORE,
        OP_COPY, OP_LOAD_LIT, OP_CONFIG, OP_RETURN, OP_FOREIGN
    } mbr_op_e;

    // Gray sequence: idle, execute, first and second flush of a two-cycle op.
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXEC   = 2'b01,
        ST_FLUSH  = 2'b11,
        ST_FLUSH2 = 2'b10
    } mbr_state_e;

endpackage

// ### common/mbr_file_if.sv
// Port bundle between the execution unit and its file register memory.
interface mbr_file_if
    import mbr_pkg::*;
;
    logic                we;
    logic [FADDR_W-1:0]  addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface // mbr_file_if

// ### logic/mbr_file_mem.sv
// File register memory with registered read data.
module mbr_file_mem
    import mbr_pkg::*;
(
    // Clock, reset and enable
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    // Access port
    mbr_file_if.mem    bus
);

    logic [DATA_W-1:0] mem_q [FILE_DEPTH];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // The array has no reset so it can map onto plain RAM cells.
    always_ff @(posedge clk) begin
        if (ce && bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.rdata <= '0;
        end else if (ce) begin
            bus.rdata <= mem_q[bus.addr];
        end
    end

endmodule // mbr_file_mem

// ### logic/mbr_exec.sv
// Execution unit for branch, OR, move, literal, configuration and return instructions.
// Function
// - Branch copies 9-bit operand into counter 8:0.
// - Branch fills counter 10:9 from flags 6:5.
// - Branch takes three cycles, flags unchanged.
// - OR literal into accumulator, zero flag updated.
// - OR accumulator with file, zero flag updated.
// - Destination bit picks accumulator or file.
// - Store accumulator to file, flags unchanged.
// - Copy file to destination, zero flag updated.
// - Copy back to file still updates zero.
// - Load literal into accumulator, flags unchanged.
// - Configuration register takes accumulator, flags unchanged.
// - Return loads literal into accumulator, flags unchanged.
// - Return reloads counter from stack top, three cycles.
module mbr_exec
    import mbr_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Instruction from fetch
    input  wire logic                instr_valid,
    input  wire logic [INSTR_W-1:0]  instr_word,
    output logic                     instr_ready,
    output logic                     done,
    output logic                     foreign,
    // Program counter and stack
    output logic [PC_W-1:0]          program_counter,
    output logic                     pc_load,
    input  wire logic [PC_W-1:0]     stack_top,
    output logic                     stack_pop,
    // Core registers
    input  wire logic                status_wr,
    input  wire logic [DATA_W-1:0]   status_wdata,
    output logic [DATA_W-1:0]        acc,
    output logic [DATA_W-1:0]        status,
    output logic [DATA_W-1:0]        option_reg,
    // File write observation
    output logic                     file_we,
    output logic [FADDR_W-1:0]       file_addr,
    output logic [DATA_W-1:0]        file_wdata
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic mbr_op_e decode(input logic [INSTR_W-1:0] iw);
        if (iw == OPC_IDLE) begin
            return OP_IDLE;
        end else if (iw == OPC_CONFIG) begin
            return OP_CONFIG;
        end else if (iw[11:9] == OPC_BRANCH) begin
            return OP_BRANCH;
        end else if (iw[11:8] == OPC_OR_LIT) begin
            return OP_OR_LIT;
        end else if (iw[11:8] == OPC_LOAD_LIT) begin
            return OP_LOAD_LIT;
        end else if (iw[11:8] == OPC_RETURN) begin
            return OP_RETURN;
        end else if (iw[11:6] == OPC_OR_FILE) begin
            return OP_OR_FILE;
        end else if (iw[11:6] == OPC_COPY) begin
            return OP_COPY;
        end else if (iw[11:5] == OPC_STORE) begin
            return OP_STORE;
        end else begin
            return OP_FOREIGN;
        end
    endfunction

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    mbr_state_e           state;
    mbr_op_e              op_q;
    logic [INSTR_W-1:0]   instr_q;
    logic [DATA_W-1:0]    result;
    logic                 two_cycle;
    logic                 exec;
    logic                 dest_file;
    logic                 z_op;
    logic                 next_we;
    mbr_file_if           u_file_bus ();

    assign instr_ready = ce && (state == ST_IDLE);
    assign exec        = ce && (state == ST_EXEC);
    assign two_cycle   = (op_q == OP_BRANCH) || (op_q == OP_RETURN);
    assign dest_file   = instr_q[DEST_BIT];
    assign z_op        = (op_q == OP_OR_LIT) || (op_q == OP_OR_FILE) || (op_q == OP_COPY);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (ce) begin
            case (state)
                ST_IDLE:  state <= instr_valid ? ST_EXEC : ST_IDLE;
                ST_EXEC:  state <= two_cycle ? ST_FLUSH : ST_IDLE;
                ST_FLUSH: state <= ST_FLUSH2;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_q <= '0;
            op_q    <= OP_IDLE;
        end else if (instr_ready && instr_valid) begin
            instr_q <= instr_word;
            op_q    <= decode(instr_word);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done    <= 1'b0;
            foreign <= 1'b0;
        end else if (ce) begin
            done    <= (state == ST_FLUSH2) || ((state == ST_EXEC) && !two_cycle);
            foreign <= (state == ST_EXEC) && (op_q == OP_FOREIGN);
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    always_comb begin
        case (op_q)
            OP_OR_LIT:  result = acc | instr_q[LIT_MSB:0];
            OP_OR_FILE: result = acc | u_file_bus.rdata;
            OP_COPY:    result = u_file_bus.rdata;
            default:    result = acc;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc <= ACC_RST;
        end else if (exec) begin
            case (op_q)
                OP_OR_LIT:   acc <= result;
                OP_OR_FILE,
                OP_COPY:     acc <= dest_file ? acc : result;
                OP_LOAD_LIT,
                OP_RETURN:   acc <= instr_q[LIT_MSB:0];
                default:     acc <= acc;
            endcase
        end
    end

    // The core may write the flags in the same cycle; the zero result of
    // this unit is applied last so an executing instruction wins bit Z.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= STATUS_RST;
        end else if (ce) begin
            if (status_wr) begin
                status <= status_wdata;
            end
            if (exec && z_op) begin
                status[ZERO_BIT] <= is_zero(result);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            option_reg <= OPTION_RST;
        end else if (exec && (op_q == OP_CONFIG)) begin
            option_reg <= acc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            program_counter <= PC_RST;
            pc_load         <= 1'b0;
            stack_pop       <= 1'b0;
        end else if (ce) begin
            pc_load   <= exec && two_cycle;
            stack_pop <= exec && (op_q == OP_RETURN);
            if (exec) begin
                case (op_q)
                    OP_BRANCH: program_counter <= {status[PAGE_HI_BIT:PAGE_LO_BIT],
                                                   instr_q[BR_K_MSB:0]};
                    OP_RETURN: program_counter <= stack_top;
                    default:   program_counter <= program_counter + 1'b1;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // File register access
    // ------------------------------------------------------------------
    assign next_we = exec && ((op_q == OP_STORE) ||
                     (((op_q == OP_OR_FILE) || (op_q == OP_COPY)) && dest_file));
    assign u_file_bus.we    = next_we;
    assign u_file_bus.addr  = (state == ST_IDLE) ? instr_word[FADDR_MSB:0] : instr_q[FADDR_MSB:0];
    assign u_file_bus.wdata = (op_q == OP_STORE) ? acc : result;

    mbr_file_mem u_file_mem (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .bus (u_file_bus.mem)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            file_we    <= 1'b0;
            file_addr  <= '0;
            file_wdata <= '0;
        end else if (ce) begin
            file_we    <= next_we;
            file_addr  <= u_file_bus.addr;
            file_wdata <= u_file_bus.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_branch_target;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_BRANCH) |=>
            program_counter == {$past(status[PAGE_HI_BIT:PAGE_LO_BIT]), $past(instr_q[BR_K_MSB:0])};
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

    property p_branch_two_cycles;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_BRANCH) ##1 ce[*2] |=> done ##1 !done;
    endproperty
    a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("branch length wrong");

    property p_flags_kept;
        @(posedge clk) disable iff (rst)
        (exec && !z_op && !status_wr) |=> status == $past(status);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_or_literal;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_OR_LIT) |=>
            acc == $past(result) && status[ZERO_BIT] == ($past(result) == 8'h00);
    endproperty
    a_or_literal: assert property (p_or_literal) else $error("or literal wrong");

    property p_dest_file;
        @(posedge clk) disable iff (rst)
        (exec && (op_q == OP_OR_FILE || op_q == OP_COPY) && dest_file) |=>
            file_we && file_addr == $past(instr_q[FADDR_MSB:0]) && acc == $past(acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

    property p_copy_zero_test;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_COPY) |=> status[ZERO_BIT] == ($past(u_file_bus.rdata) == 8'h00);
    endproperty
    a_copy_zero_test: assert property (p_copy_zero_test) else $error("zero test wrong");

    property p_return;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_RETURN) |=>
            acc == $past(instr_q[LIT_MSB:0]) && program_counter == $past(stack_top) && stack_pop;
    endproperty
    a_return: assert property (p_return) else $error("return wrong");

    property p_idle;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_IDLE) |=>
            acc == $past(acc) && !file_we && program_counter == $past(program_counter) + 11'h001 && done;
    endproperty
    a_idle: assert property (p_idle) else $error("idle instruction changed state");

    property p_config;
        @(posedge clk) disable iff (rst)
        (exec && op_q == OP_CONFIG) |=> option_reg == $past(acc) && done;
    endproperty
    a_config: assert property (p_config) else $error("configuration load wrong");

    property p_single_cycle;
        @(posedge clk) disable iff (rst)
        (instr_ready && instr_valid && !(decode(instr_word) inside {OP_BRANCH, OP_RETURN})) ##1 ce |=> done;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("single-cycle op too slow");
endmodule // mbr_exec

// ### test/tb_mbr_exec.sv
// Self-checking bench for the execution unit, with a reference model of its instructions.
module tb_mbr_exec
    import mbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                clk = 1'b0;
    logic                rst;
    logic                ce;
    logic                instr_valid;
    logic [INSTR_W-1:0]  instr_word;
    logic                instr_ready;
    logic                done;
    logic                foreign;
    logic [PC_W-1:0]     program_counter;
    logic                pc_load;
    logic [PC_W-1:0]     stack_top;
    logic                stack_pop;
    logic                status_wr;
    logic [DATA_W-1:0]   status_wdata;
    logic [DATA_W-1:0]   acc;
    logic [DATA_W-1:0]   status;
    logic [DATA_W-1:0]   option_reg;
    logic                file_we;
    logic [FADDR_W-1:0]  file_addr;
    logic [DATA_W-1:0]   file_wdata;

    // Reference model state; file contents are only read after the fill test writes them all.
    logic [DATA_W-1:0]   m_acc;
    logic [DATA_W-1:0]   m_st;
    logic [DATA_W-1:0]   m_opt;
    logic [PC_W-1:0]     m_pc;
    logic [DATA_W-1:0]   fm [FILE_DEPTH];
    int                  mismatches = 0;
    int                  compares = 0;
    int                  cycles = 0;
    int                  seed = 32'h8200_8262;

    always #2.5 clk = ~clk;

    mbr_exec dut_u (
        .clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .done(done), .foreign(foreign), .program_counter(program_counter),
        .pc_load(pc_load), .stack_top(stack_top), .stack_pop(stack_pop), .status_wr(status_wr),
        .status_wdata(status_wdata), .acc(acc), .status(status), .option_reg(option_reg),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata)
    );

    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pc(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t counter got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp, input string what);
        compares++;
        if (got != exp) begin
            mismatches++;
            $display("ERROR %0t %s in cycle %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 10000) begin
            mismatches++;
            $display("ERROR %0t run did not finish", $time);
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // One instruction: model, drive, observe, compare
    // ------------------------------------------------------------------
    task automatic run(input logic [INSTR_W-1:0] w, input bit stall);
        logic [7:0]  r;
        logic [7:0]  ewd;
        logic [7:0]  wdat;
        logic [4:0]  waddr;
        logic [10:0] ret;
        int          n;
        int          s;
        int          base;
        int          epl;
        int          epop;
        int          ewe;
        int          efg;
        int          pl;
        int          pop;
        int          we;
        int          fg;
        int          rdy;
        base = 1; epl = 0; epop = 0; ewe = 0; efg = 0; ewd = 8'h00; s = stall ? 3 : 0;
        pl = 0; pop = 0; we = 0; fg = 0; wdat = 8'h00; waddr = 5'h00; rdy = 0;
        ret = 11'($random(seed));
        if (w[11:9] == OPC_BRANCH) begin
            m_pc = {m_st[PAGE_HI_BIT:PAGE_LO_BIT], w[8:0]};
            base = 3; epl = 1;
        end else if (w[11:8] == OPC_RETURN) begin
            m_acc = w[7:0]; m_pc = ret;
            base = 3; epl = 1; epop = 1;
        end else begin
            m_pc = m_pc + 11'h001;
            if (w[11:8] == OPC_OR_LIT) begin
                m_acc = m_acc | w[7:0];
                m_st[ZERO_BIT] = (m_acc == 8'h00);
            end else if (w[11:8] == OPC_LOAD_LIT) begin
                m_acc = w[7:0];
            end else if (w[11:6] == OPC_OR_FILE || w[11:6] == OPC_COPY) begin
                r = (w[11:6] == OPC_COPY) ? fm[w[4:0]] : (fm[w[4:0]] | m_acc);
                m_st[ZERO_BIT] = (r == 8'h00);
                if (w[DEST_BIT]) begin
                    fm[w[4:0]] = r; ewe = 1; ewd = r;
                end else begin
                    m_acc = r;
                end
            end else if (w[11:5] == OPC_STORE) begin
                fm[w[4:0]] = m_acc; ewe = 1; ewd = m_acc;
            end else if (w == OPC_CONFIG) begin
                m_opt = m_acc;
            end else if (w != OPC_IDLE) begin
                efg = 1;
            end
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        stack_top   <= ret;
        @(negedge clk);
        for (n = 0; n < 20 && instr_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_word  <= 12'($random(seed));
        if (stall) ce <= 1'b0;
        for (n = 1; n <= 40; n++) begin
            @(posedge clk);
            if (stall) ce <= (n >= 3);
            @(negedge clk);
            if (pc_load === 1'b1) pl = n;
            if (stack_pop === 1'b1) pop = n;
            if (foreign === 1'b1) fg = n;
            if (file_we === 1'b1) begin
                we = n; waddr = file_addr; wdat = file_wdata;
            end
            if (instr_ready === 1'b1) rdy++;
            if (done === 1'b1) break;
        end
        chk_n(n, base + s, "done");
        chk_n(rdy, 1, "ready samples");
        chk_n(pl, epl ? epl + s : 0, "load pulse");
        chk_n(pop, epop ? epop + s : 0, "pop pulse");
        chk_n(we, ewe ? 1 + s : 0, "file write");
        chk_n(fg, efg ? 1 + s : 0, "foreign");
        chk_pc(program_counter, m_pc);
        chk8(acc, m_acc, "acc");
        chk8(status, m_st, "status");
        chk8(option_reg, m_opt, "option");
        if (ewe) chk8(wdat, ewd, "file data");
        if (ewe) chk8({3'b000, waddr}, {3'b000, w[4:0]}, "file address");
    endtask

    task automatic set_status(input logic [7:0] v);
        @(posedge clk);
        status_wr    <= 1'b1;
        status_wdata <= v;
        @(posedge clk);
        status_wr    <= 1'b0;
        status_wdata <= 8'($random(seed));
        m_st = v;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [INSTR_W-1:0] w;
        int                 i;
        rst = 1'b1; ce = 1'b1; instr_valid = 1'b0; instr_word = 12'h000;
        stack_top = 11'h000; status_wr = 1'b0; status_wdata = 8'h00;
        m_acc = ACC_RST; m_st = STATUS_RST; m_opt = OPTION_RST; m_pc = PC_RST;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < FILE_DEPTH; i++) begin
            run({OPC_LOAD_LIT, (i == 7) ? 8'h00 : 8'($random(seed))}, 1'b0);
            run({OPC_STORE, 5'(i)}, 1'b0);
        end
        $display("test fill done at %0t", $time);
        run({OPC_LOAD_LIT, 8'h00}, 1'b0);
        run({OPC_OR_LIT, 8'h00}, 1'b0);
        run({OPC_OR_LIT, 8'h40}, 1'b0);
        run({OPC_COPY, 1'b1, 5'd7}, 1'b0);
        run({OPC_OR_FILE, 1'b1, 5'd3}, 1'b0);
        run({OPC_OR_FILE, 1'b0, 5'd7}, 1'b0);
        run({OPC_COPY, 1'b0, 5'd7}, 1'b0);
        $display("test zero flag done at %0t", $time);
        for (i = 0; i < 4; i++) begin
            w = 12'($random(seed));
            set_status({w[7], 2'(i), w[4:0]});
            run({OPC_BRANCH, (i % 2) ? 9'h1ff : 9'h000}, 1'b0);
        end
        $display("test branch pages done at %0t", $time);
        run({OPC_RETURN, 8'hff}, 1'b1);
        run(OPC_CONFIG, 1'b0);
        run(OPC_IDLE, 1'b0);
        run(12'h003, 1'b0);
        $display("test return config idle done at %0t", $time);
        for (i = 0; i < 150; i++) begin
            w = 12'($random(seed));
            case (unsigned'($random(seed)) % 9)
                0: w = {OPC_BRANCH, w[8:0]};
                1: w = {OPC_OR_LIT, w[7:0]};
                2: w = {OPC_LOAD_LIT, w[7:0]};
                3: w = {OPC_RETURN, w[7:0]};
                4: w = {OPC_OR_FILE, w[5:0]};
                5: w = {OPC_COPY, w[5:0]};
                6: w = {OPC_STORE, w[4:0]};
                7: w = OPC_CONFIG;
                default: w = OPC_IDLE;
            endcase
            run(w, (i % 7) == 3);
        end
        $display("test random mix done at %0t", $time);
        close_out();
    end

endmodule // tb_mbr_exec
